/* dv/lmc_checker.sv */
// Port checks for the line maintenance control block
`timescale 1ns/1ps
module lmc_checker
	import lmc_pkg::*;
#(
	parameter int MCLK_DIV = LMC_MCLK_DIV
) (
	input wire logic                  i_clk,
	input wire logic                  i_rst,
	input wire logic                  i_psel,
	input wire logic                  i_penable,
	input wire logic                  i_pwrite,
	input wire logic [LMC_ADDR_W-1:0] i_paddr,
	input wire logic [31:0]           i_pwdata,
	input wire logic [31:0]           o_prdata,
	input wire logic                  o_pready,
	input wire logic                  o_pslverr,
	input wire logic                  o_tx_line_tip,
	input wire logic                  o_tx_line_ring,
	input wire logic                  o_tx_bit_strobe,
	input wire logic                  o_pseudo_random_invert,
	input wire logic                  o_loss_criterion_select,
	input wire logic                  o_auto_far_end_loopback_enable,
	input wire logic                  o_far_end_loopback_enable,
	input wire logic                  o_analog_loopback_enable,
	input wire logic                  o_digital_loopback_enable,
	input wire logic [1:0]            o_rx_activate_code_length,
	input wire logic [1:0]            o_rx_deactivate_code_length
);
	logic wr;
	assign wr = i_psel && i_penable && o_pready && i_pwrite;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	////////////////////////////////////////////////////////////////////////////
	chk_one_wait: assert property (i_psel && i_penable && !$past(i_penable) |-> !o_pready ##1 o_pready)
		else $error("ready not after one wait state");
	chk_ctl_mirror: assert property (wr && i_paddr == 12'h034 |=>
		{o_pseudo_random_invert, o_loss_criterion_select} == $past(i_pwdata[3:2]))
		else $error("invert or criterion output wrong");
	chk_loop_mirror: assert property (wr && i_paddr == 12'h038 |=> {o_auto_far_end_loopback_enable,
		o_far_end_loopback_enable, o_analog_loopback_enable, o_digital_loopback_enable} == $past(i_pwdata[3:0]))
		else $error("loopback outputs wrong");
	chk_len_mirror: assert property (wr && i_paddr == 12'h3C0 |=>
		{o_rx_activate_code_length, o_rx_deactivate_code_length} == $past(i_pwdata[3:0]))
		else $error("receive code lengths wrong");
	chk_rails_excl: assert property (!(o_tx_line_tip && o_tx_line_ring))
		else $error("both rails marked");
	chk_rails_hold: assert property (!o_tx_bit_strobe |-> $stable({o_tx_line_tip, o_tx_line_ring}))
		else $error("rails changed off a bit boundary");
	chk_err_zero: assert property (o_pslverr |-> o_pready && (i_pwrite || o_prdata == 32'h0))
		else $error("error answer malformed");
	chk_upper_zero: assert property (o_pready && !i_pwrite |-> o_prdata[31:8] == 24'h0)
		else $error("reserved read bits set");
endmodule // lmc_checker

bind lmc_line_maintenance_control lmc_checker #(.MCLK_DIV(MCLK_DIV)) u_chk (.i_clk, .i_rst, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_tx_line_tip, .o_tx_line_ring, .o_tx_bit_strobe,
	.o_pseudo_random_invert, .o_loss_criterion_select, .o_auto_far_end_loopback_enable, .o_far_end_loopback_enable,
	.o_analog_loopback_enable, .o_digital_loopback_enable, .o_rx_activate_code_length, .o_rx_deactivate_code_length);

/* dv/lmc_line_model.sv */
// Line-side model: free transmit clock and receive rails
`timescale 1ns/1ps
module lmc_line_model #(
	parameter real HALF_NS = 80.0
) (
	input  wire logic i_loss,
	output logic      o_tx_clock_in,
	output logic      o_rx_pos,
	output logic      o_rx_neg,
	output logic      o_rx_clk
);
	logic phase;
	initial begin
		{o_tx_clock_in, o_rx_pos, o_rx_neg, phase} = '0;
		#3.3;
		forever begin
			#(HALF_NS) o_tx_clock_in = !o_tx_clock_in;
			if (o_tx_clock_in) begin
				// Alternate marks; a lost line carries none
				phase = !phase;
				o_rx_pos = !i_loss && phase;
				o_rx_neg = !i_loss && !phase;
			end
		end
	end
	assign o_rx_clk = o_tx_clock_in;
endmodule // lmc_line_model

/* dv/lmc_tb.sv */
// Self-checking bench for the line maintenance control block
`timescale 1ns/1ps
module tb;
	import lmc_pkg::*;
	localparam int DIV = 4;
	logic i_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic i_tx_data = 1'b0, i_e1_mode = 1'b1, i_loss_of_signal = 1'b0;
	logic [11:0] i_paddr = '0;
	logic [31:0] i_pwdata = '0, o_prdata;
	logic o_pready, o_pslverr, i_tx_clock_in, i_rx_data_positive, i_rx_data_negative, i_rx_clock;
	logic o_tx_line_tip, o_tx_line_ring, o_tx_bit_strobe, o_rx_data_positive, o_rx_data_negative, o_rx_clock;
	logic o_pseudo_random_invert, o_loss_criterion_select, o_auto_far_end_loopback_enable;
	logic o_far_end_loopback_enable, o_analog_loopback_enable, o_digital_loopback_enable;
	logic [1:0] o_rx_activate_code_length, o_rx_deactivate_code_length;
	logic [7:0] o_rx_activate_code, o_rx_deactivate_code;
	logic bits[64];
	int gap[64];
	int failures = 0, tests_run = 0;
	always #5 i_clk = ~i_clk;
	lmc_line_maintenance_control #(.MCLK_DIV(DIV)) dut (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_tx_clock_in, .i_tx_data, .i_e1_mode, .i_loss_of_signal,
		.i_rx_data_positive, .i_rx_data_negative, .i_rx_clock, .o_tx_line_tip, .o_tx_line_ring, .o_tx_bit_strobe,
		.o_rx_data_positive, .o_rx_data_negative, .o_rx_clock, .o_pseudo_random_invert, .o_loss_criterion_select,
		.o_auto_far_end_loopback_enable, .o_far_end_loopback_enable, .o_analog_loopback_enable,
		.o_digital_loopback_enable, .o_rx_activate_code_length, .o_rx_activate_code, .o_rx_deactivate_code_length,
		.o_rx_deactivate_code);
	lmc_line_model u_line (.i_loss(i_loss_of_signal), .o_tx_clock_in(i_tx_clock_in), .o_rx_pos(i_rx_data_positive),
		.o_rx_neg(i_rx_data_negative), .o_rx_clk(i_rx_clock));
	////////////////////////////////////////////////////////////////////////////
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic hang();
		failures++;
		results();
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		for (int n = 0; n <= 20; n++) begin
			if (n == 20) hang();
			@(posedge i_clk);
			if (o_pready === 1'b1) break;
		end
		r = o_prdata;
		e = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rchk(string nm, logic [11:0] a, logic [31:0] exp, logic ee);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, '0, r, e);
		check(nm, r, exp);
		check(nm, e, ee);
	endtask
	// Collect marks at bit boundaries, checking alternate-mark polarity
	task automatic get_bits(int cnt);
		int n;
		logic have, last;
		have = 0;
		last = 0;
		for (int k = 0; k < cnt; k++) begin
			for (n = 1; o_tx_bit_strobe !== 1'b1; n++) begin
				if (n == 400) hang();
				@(negedge i_clk);
			end
			bits[k] = o_tx_line_tip | o_tx_line_ring;
			gap[k] = n;
			if (bits[k] && have) check("ami_tip", o_tx_line_tip, !last);
			if (bits[k]) begin
				have = 1;
				last = o_tx_line_tip;
			end
			@(negedge i_clk);
		end
	endtask
	function automatic int ones(int a, int b);
		ones = 0;
		for (int k = a; k <= b; k++) ones += bits[k];
	endfunction
	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rchk("seq_rst", 12'h034, 32'h00, 1'b0);
		rchk("loop_rst", 12'h038, 32'h00, 1'b0);
		rchk("txcode_rst", 12'h040, 32'h01, 1'b0);
		rchk("act_rst", 12'h044, 32'h01, 1'b0);
		rchk("len_rst", 12'h3C0, 32'h01, 1'b0);
		rchk("unmapped", 12'h3C4, 32'h00, 1'b1);
		check("act_code_out", o_rx_activate_code, 8'h01);
		wr(12'h034, 32'hFFFFFFFF);
		wr(12'h038, 32'hFFFFFFFF);
		wr(12'h3C0, 32'hFFFFFFFF);
		rchk("seq_resv", 12'h034, 32'h7F, 1'b0);
		rchk("loop_resv", 12'h038, 32'h0F, 1'b0);
		rchk("len_resv", 12'h3C0, 32'h3F, 1'b0);
		check("inv_out", o_pseudo_random_invert, 1'b1);
		check("loop_out", {o_far_end_loopback_enable, o_digital_loopback_enable}, 2'h3);
		wr(12'h038, 32'h0);
	endtask
	task automatic t_ones_zeros();
		wr(12'h034, 32'h20);
		get_bits(10);
		check("all_ones", ones(2, 9), 8);
		@(posedge i_clk);
		i_tx_data <= 1'b1;
		wr(12'h034, 32'h10);
		get_bits(6);
		check("all_zeros", ones(2, 5), 0);
		check("mclk_gap", gap[4], DIV);
		wr(12'h034, 32'h00);
		get_bits(6);
		check("normal_data", ones(2, 5), 4);
	endtask
	task automatic t_code();
		int hit, bad;
		hit = 0;
		wr(12'h3C0, 32'h11);
		wr(12'h040, 32'hCB);
		wr(12'h034, 32'h70);
		get_bits(24);
		for (int r = 0; r < 6; r++) begin
			bad = 0;
			for (int k = 4; k < 24; k++) bad += (bits[k] != ((8'hCB >> (5 - (k + r) % 6)) & 1));
			if (bad == 0) hit = 1;
		end
		check("code_seq", hit, 1);
	endtask
	task automatic t_prbs();
		int bad, len, d;
		for (int i = 0; i < 3; i++) begin
			@(posedge i_clk);
			i_e1_mode <= (i != 1);
			wr(12'h034, (i == 2) ? 32'h58 : 32'h50);
			len = (i != 1) ? 15 : 20;
			d = (i != 1) ? 1 : 3;
			bad = 0;
			get_bits(52);
			for (int m = 4 + len; m < 52; m++) bad += (bits[m] != (bits[m - len] ^ bits[m - len + d] ^ (i == 2)));
			check("prbs_rule", bad, 0);
		end
	endtask
	task automatic t_loss();
		int c;
		@(posedge i_clk);
		i_tx_data <= 1'b0;
		wr(12'h034, 32'h31);
		get_bits(6);
		check("ones_no_loss", ones(2, 5), 0);
		@(posedge i_clk);
		i_loss_of_signal <= 1'b1;
		get_bits(6);
		check("ones_loss", ones(2, 5), 4);
		for (int f = 0; f < 2; f++) begin
			wr(12'h034, f ? 32'h13 : 32'h11);
			get_bits(6);
			check("sel00_loss", ones(2, 5), 0);
			c = 0;
			repeat (8 * DIV) @(negedge i_clk) c += o_rx_data_positive | o_rx_data_negative;
			check("rx_fill", c > 0, f);
		end
	endtask
	initial begin
		repeat (20) @(posedge i_clk);
		i_rst <= 1'b0;
		t_regs();
		t_ones_zeros();
		t_code();
		t_prbs();
		t_loss();
		results();
	end
endmodule // tb

/* rtl/lmc_line_maintenance_control.sv */
// Line maintenance control: APB register bank, test sequence generator, loopback and alarm fill
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Select 00: normal data, or zeros if master-clocked
// - Select 01: all ones, or normal data until loss if auto ones set
// - Select 10: PRBS15 in E1, QRSS20 in T1
// - Select 11: repeat programmed in-band code
// - Sequence clocked by transmit clock or master clock
// - Invert pseudo-random data when invert bit set
// - Criterion bit chooses loss/alarm detection set
// - Alarm fill forces ones on receive outputs
// - Auto ones on loss only with select 01
// - Auto far-end loopback enable bit
// - Far-end loopback returns receive data to line
// - Analog loopback enable bit
// - Digital loopback enable bit
// - Transmit code length: 5 to 8 bits
// - Receive activate code length: 5 to 8 bits
// - Receive deactivate code length, reset 6 bits
// - Transmit code register, reset 00001
// - Receive activate code register, reset 00001
module lmc_line_maintenance_control
	import lmc_pkg::*;
#(
	parameter int MCLK_DIV = LMC_MCLK_DIV
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	input  wire logic                  i_psel,
	input  wire logic                  i_penable,
	input  wire logic                  i_pwrite,
	input  wire logic [LMC_ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]           i_pwdata,
	output logic      [31:0]           o_prdata,
	output logic                       o_pready,
	output logic                       o_pslverr,
	input  wire logic                  i_tx_clock_in,
	input  wire logic                  i_tx_data,
	input  wire logic                  i_e1_mode,
	input  wire logic                  i_loss_of_signal,
	input  wire logic                  i_rx_data_positive,
	input  wire logic                  i_rx_data_negative,
	input  wire logic                  i_rx_clock,
	output logic                       o_tx_line_tip,
	output logic                       o_tx_line_ring,
	output logic                       o_tx_bit_strobe,
	output logic                       o_rx_data_positive,
	output logic                       o_rx_data_negative,
	output logic                       o_rx_clock,
	output logic                       o_pseudo_random_invert,
	output logic                       o_loss_criterion_select,
	output logic                       o_auto_far_end_loopback_enable,
	output logic                       o_far_end_loopback_enable,
	output logic                       o_analog_loopback_enable,
	output logic                       o_digital_loopback_enable,
	output logic      [1:0]            o_rx_activate_code_length,
	output logic      [7:0]            o_rx_activate_code,
	output logic      [1:0]            o_rx_deactivate_code_length,
	output logic      [7:0]            o_rx_deactivate_code
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		lmc_seq_t    sel;
		logic        clk_src;
		logic        pseudo_random_invert;
		logic        loss_crit;
		logic        ais_en;
		logic        auto_ones;
		logic [3:0]  lb;
		logic [1:0]  tx_len;
		logic [1:0]  ra_len;
		logic [1:0]  rd_len;
		logic [7:0]  tx_code;
		logic [7:0]  ra_code;
		logic [7:0]  rd_code;
		lmc_seq_t    act_sel;
		logic [2:0]  sync;
		logic        clk_lvl;
		logic [15:0] div_cnt;
		logic [19:0] lfsr;
		logic [2:0]  code_idx;
		logic        tx_vld;
		logic        tip;
		logic        ring;
		logic        mark_pol;
		logic        rx_pos;
		logic        rx_neg;
		logic        rx_clk;
		logic        ais_pol;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} lmc_state_t;

	lmc_state_t st;
	lmc_state_t next_st;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Word index from byte address; flags a misaligned or out-of-range address
	function automatic logic [8:0] lmc_index(input logic [LMC_ADDR_W-1:0] addr);
		logic [LMC_ADDR_W-3:0] w;
		w = addr[LMC_ADDR_W-1:2];
		lmc_index = {(addr[1:0] != 2'h0) || (w > 10'h0FF), w[7:0]};
	endfunction

	// Highest bit of a code for length field 00..11 gives 4..7
	function automatic logic [2:0] lmc_top(input logic [1:0] len);
		lmc_top = {1'b1, len};
	endfunction

	logic [8:0] idx;
	logic       bus_access;
	logic       div_en;
	logic       tx_clock_in_rise;
	logic       bit_en;
	logic       lfsr_fb;
	logic       prbs_bit;
	logic       normal_bit;
	logic       tx_bit;
	logic       rx_line_bit;

	always_comb begin
		idx        = lmc_index(i_paddr);
		bus_access = i_psel && i_penable && st.pready;
		div_en     = st.div_cnt == 16'(MCLK_DIV - 1);
		tx_clock_in_rise  = (st.sync[1] == st.sync[2]) && st.sync[2] && !st.clk_lvl;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_st = st;

		// APB slave: one wait state, read data registered at the wait-state edge, write at the completing edge
		next_st.pready  = i_psel && i_penable && !st.pready;
		next_st.pslverr = 1'b0;
		if (i_psel && i_penable && !st.pready) begin
			next_st.prdata  = 32'h0000_0000;
			next_st.pslverr = idx[8];
			if (!idx[8] && !i_pwrite) begin
				// Reserved bits read zero
				case (idx[7:0])
					LMC_IDX_TEST_SEQ: next_st.prdata[7:0] = {1'b0, st.sel, st.clk_src, st.pseudo_random_invert,
						st.loss_crit, st.ais_en, st.auto_ones};
					LMC_IDX_LOOPBACK: next_st.prdata[7:0] = {4'h0, st.lb};
					LMC_IDX_TX_CODE:  next_st.prdata[7:0] = st.tx_code;
					LMC_IDX_RX_ACT:   next_st.prdata[7:0] = st.ra_code;
					LMC_IDX_RX_DEACT: next_st.prdata[7:0] = st.rd_code;
					LMC_IDX_CODE_LEN: next_st.prdata[7:0] = {2'h0, st.tx_len, st.ra_len, st.rd_len};
					default:          next_st.pslverr = 1'b1;
				endcase
			end else if (!idx[8]) begin
				case (idx[7:0])
					LMC_IDX_TEST_SEQ, LMC_IDX_LOOPBACK, LMC_IDX_TX_CODE,
					LMC_IDX_RX_ACT, LMC_IDX_RX_DEACT, LMC_IDX_CODE_LEN: next_st.pslverr = 1'b0;
					default: next_st.pslverr = 1'b1;
				endcase
			end
		end
		if (bus_access && i_pwrite && !idx[8]) begin
			// Only defined bits are stored
			case (idx[7:0])
				LMC_IDX_TEST_SEQ: begin
					next_st.sel       = lmc_seq_t'(i_pwdata[LMC_SEL_LSB+:2]);
					next_st.clk_src   = i_pwdata[LMC_CLK_SRC_BIT];
					next_st.pseudo_random_invert  = i_pwdata[LMC_INV_BIT];
					next_st.loss_crit = i_pwdata[LMC_CRIT_BIT];
					next_st.ais_en    = i_pwdata[LMC_AIS_BIT];
					next_st.auto_ones = i_pwdata[LMC_ONES_BIT];
				end
				LMC_IDX_LOOPBACK: next_st.lb = i_pwdata[3:0];
				LMC_IDX_TX_CODE:  next_st.tx_code = i_pwdata[7:0];
				LMC_IDX_RX_ACT:   next_st.ra_code = i_pwdata[7:0];
				LMC_IDX_RX_DEACT: next_st.rd_code = i_pwdata[7:0];
				LMC_IDX_CODE_LEN: begin
					next_st.tx_len = i_pwdata[LMC_TXLEN_LSB+:2];
					next_st.ra_len = i_pwdata[LMC_RALEN_LSB+:2];
					next_st.rd_len = i_pwdata[LMC_RDLEN_LSB+:2];
				end
				default: next_st.pslverr = 1'b0;
			endcase
		end

		// Transmit clock pin: three flops, edge once the last two agree
		next_st.sync = {st.sync[1:0], i_tx_clock_in};
		if (st.sync[1] == st.sync[2]) begin
			next_st.clk_lvl = st.sync[2];
		end

		// Master clock bit-rate divider
		next_st.div_cnt = div_en ? 16'h0000 : st.div_cnt + 16'h0001;

		// Bit boundary from the selected reference
		bit_en = st.clk_src ? div_en : tx_clock_in_rise;

		// PRBS15 for E1, QRSS20 for T1/J1
		lfsr_fb  = i_e1_mode ? (st.lfsr[14] ^ st.lfsr[13]) : (st.lfsr[19] ^ st.lfsr[16]);
		prbs_bit = (i_e1_mode ? st.lfsr[14] : st.lfsr[19]) ^ st.pseudo_random_invert;

		rx_line_bit = i_rx_data_positive || i_rx_data_negative;
		// Far-end loopback replaces user data
		normal_bit  = st.lb[LMC_FELP_BIT] ? rx_line_bit : i_tx_data;

		case (st.sel)
			LMC_SEQ_NORMAL: tx_bit = st.clk_src ? 1'b0 : normal_bit;
			LMC_SEQ_ONES:   tx_bit = (st.auto_ones && !i_loss_of_signal) ? normal_bit : 1'b1;
			LMC_SEQ_PRBS:   tx_bit = prbs_bit;
			LMC_SEQ_CODE: begin
				if (st.act_sel != LMC_SEQ_CODE) begin
					tx_bit = st.tx_code[lmc_top(st.tx_len)];
				end else begin
					tx_bit = st.tx_code[st.code_idx];
				end
			end
			default:        tx_bit = normal_bit;
		endcase

		next_st.tx_vld = 1'b0;
		if (bit_en) begin
			// Mode change latched only at a bit boundary
			next_st.act_sel = st.sel;
			next_st.tx_vld  = 1'b1;
			if (st.sel == LMC_SEQ_PRBS) begin
				next_st.lfsr = (st.lfsr[19:0] == 20'h00000) ? LMC_LFSR_SEED : {st.lfsr[18:0], lfsr_fb};
			end
			if (st.sel == LMC_SEQ_CODE) begin
				if (st.act_sel != LMC_SEQ_CODE) begin
					next_st.code_idx = lmc_top(st.tx_len) - 3'h1;
				end else if (st.code_idx == 3'h0) begin
					next_st.code_idx = lmc_top(st.tx_len);
				end else begin
					next_st.code_idx = st.code_idx - 3'h1;
				end
			end
			// Alternate mark inversion onto the line pair
			next_st.tip  = tx_bit && !st.mark_pol;
			next_st.ring = tx_bit && st.mark_pol;
			if (tx_bit) begin
				next_st.mark_pol = !st.mark_pol;
			end
		end

		// Receive side outputs
		if (st.ais_en && i_loss_of_signal) begin
			// Alarm fill: all ones at master bit rate
			next_st.rx_clk = div_en;
			if (div_en) begin
				next_st.rx_pos  = !st.ais_pol;
				next_st.rx_neg  = st.ais_pol;
				next_st.ais_pol = !st.ais_pol;
			end
		end else if (st.lb[LMC_DLP_BIT]) begin
			// Digital loopback: transmit pair returned to receive outputs
			next_st.rx_pos = st.tip;
			next_st.rx_neg = st.ring;
			next_st.rx_clk = st.tx_vld;
		end else begin
			next_st.rx_pos = i_rx_data_positive;
			next_st.rx_neg = i_rx_data_negative;
			next_st.rx_clk = i_rx_clock;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st           <= '0;
			st.sel       <= lmc_seq_t'(LMC_RST_TEST_SEQ[LMC_SEL_LSB+:2]);
			st.act_sel   <= lmc_seq_t'(LMC_RST_TEST_SEQ[LMC_SEL_LSB+:2]);
			st.lb        <= LMC_RST_LOOPBACK[3:0];
			st.tx_len    <= LMC_RST_TXLEN;
			st.ra_len    <= LMC_RST_RALEN;
			st.rd_len    <= LMC_RST_RDLEN;
			st.tx_code   <= LMC_RST_TX_CODE;
			st.ra_code   <= LMC_RST_RX_ACT;
			st.rd_code   <= LMC_RST_RX_DEACT;
			st.lfsr      <= LMC_LFSR_SEED;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign o_prdata                       = st.prdata;
	assign o_pready                       = st.pready;
	assign o_pslverr                      = st.pslverr;
	assign o_tx_line_tip                  = st.tip;
	assign o_tx_line_ring                 = st.ring;
	assign o_tx_bit_strobe                = st.tx_vld;
	assign o_rx_data_positive             = st.rx_pos;
	assign o_rx_data_negative             = st.rx_neg;
	assign o_rx_clock                     = st.rx_clk;
	assign o_pseudo_random_invert         = st.pseudo_random_invert;
	assign o_loss_criterion_select        = st.loss_crit;
	assign o_auto_far_end_loopback_enable = st.lb[LMC_AUTO_FAR_END_LOOPBACK_ENABLE_BIT];
	assign o_far_end_loopback_enable      = st.lb[LMC_FELP_BIT];
	assign o_analog_loopback_enable       = st.lb[LMC_ALP_BIT];
	assign o_digital_loopback_enable      = st.lb[LMC_DLP_BIT];
	assign o_rx_activate_code_length      = st.ra_len;
	assign o_rx_activate_code             = st.ra_code;
	assign o_rx_deactivate_code_length    = st.rd_len;
	assign o_rx_deactivate_code           = st.rd_code;

endmodule // lmc_line_maintenance_control

/* rtl/lmc_pkg.sv */
// Package for the line maintenance control block: map, fields, resets, timing
package lmc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0]  LMC_IDX_TEST_SEQ   = 8'h0D;
	localparam logic [7:0]  LMC_IDX_LOOPBACK   = 8'h0E;
	localparam logic [7:0]  LMC_IDX_TX_CODE    = 8'h10;
	localparam logic [7:0]  LMC_IDX_RX_ACT     = 8'h11;
	localparam logic [7:0]  LMC_IDX_RX_DEACT   = 8'h12;
	localparam logic [7:0]  LMC_IDX_CODE_LEN   = 8'hF0;
	localparam int          LMC_ADDR_W         = 12;

	// test_sequence_control fields
	localparam int          LMC_SEL_LSB        = 5;
	localparam int          LMC_CLK_SRC_BIT    = 4;
	localparam int          LMC_INV_BIT        = 3;
	localparam int          LMC_CRIT_BIT       = 2;
	localparam int          LMC_AIS_BIT        = 1;
	localparam int          LMC_ONES_BIT       = 0;
	// loopback_control fields
	localparam int          LMC_AUTO_FAR_END_LOOPBACK_ENABLE_BIT       = 3;
	localparam int          LMC_FELP_BIT       = 2;
	localparam int          LMC_ALP_BIT        = 1;
	localparam int          LMC_DLP_BIT        = 0;
	// inband_code_length fields
	localparam int          LMC_TXLEN_LSB      = 4;
	localparam int          LMC_RALEN_LSB      = 2;
	localparam int          LMC_RDLEN_LSB      = 0;

	// Reset values
	localparam logic [7:0]  LMC_RST_TEST_SEQ   = 8'h00;
	localparam logic [7:0]  LMC_RST_LOOPBACK   = 8'h00;
	localparam logic [7:0]  LMC_RST_TX_CODE    = 8'h01;
	localparam logic [7:0]  LMC_RST_RX_ACT     = 8'h01;
	localparam logic [7:0]  LMC_RST_RX_DEACT   = 8'h09;
	localparam logic [1:0]  LMC_RST_TXLEN      = 2'h0;
	localparam logic [1:0]  LMC_RST_RALEN      = 2'h0;
	localparam logic [1:0]  LMC_RST_RDLEN      = 2'h1;
	localparam logic [19:0] LMC_LFSR_SEED      = 20'hFFFFF;

	// Master-clock bit-rate divider (cycles of i_clk per bit)
	localparam int          LMC_MCLK_DIV       = 49;

	typedef enum logic [1:0] {
		LMC_SEQ_NORMAL,
		LMC_SEQ_ONES,
		LMC_SEQ_PRBS,
		LMC_SEQ_CODE
	} lmc_seq_t;
endpackage
